// >>> rtl/vic_pkg.sv
// Package for the vectored interrupt controller: register map, field
// masks, reset values and the arbitration result carrier.
// Assumes a 32-bit register port with full byte addresses.
package vic_pkg;

  // Register byte addresses
  localparam logic [31:0] VIC_NRM_STA = 32'hFFFF0000; // Normal status, read only
  localparam logic [31:0] VIC_NRM_RAW = 32'hFFFF0004; // Normal raw signals
  localparam logic [31:0] VIC_NRM_EN = 32'hFFFF0008; // Normal enables
  localparam logic [31:0] VIC_SOFT_CFG = 32'hFFFF0010; // Programmed interrupts
  localparam logic [31:0] VIC_TBL_BASE = 32'hFFFF0014; // Vector table base
  localparam logic [31:0] VIC_NRM_VEC = 32'hFFFF001C; // Normal vector output
  localparam logic [31:0] VIC_PRIO0 = 32'hFFFF0020; // Priority register 0
  localparam logic [31:0] VIC_PRIO1 = 32'hFFFF0024; // Priority register 1
  localparam logic [31:0] VIC_PRIO2 = 32'hFFFF0028; // Priority register 2
  localparam logic [31:0] VIC_VEC_CTRL = 32'hFFFF002C; // Vector enable control
  localparam logic [31:0] VIC_NRM_EOI = 32'hFFFF0030; // Normal end of handler
  localparam logic [31:0] VIC_FST_STA = 32'hFFFF0100; // Fast status, read only
  localparam logic [31:0] VIC_FST_RAW = 32'hFFFF0104; // Fast raw signals
  localparam logic [31:0] VIC_FST_EN = 32'hFFFF0108; // Fast enables
  localparam logic [31:0] VIC_FST_VEC = 32'hFFFF011C; // Fast vector output
  localparam logic [31:0] VIC_FST_EOI = 32'hFFFF0130; // Fast end of handler
  localparam logic [31:0] VIC_EVT_STA = 32'hFFFF0140; // Event status, W1C
  localparam logic [31:0] VIC_EVT_MASK = 32'hFFFF0144; // Event mask

  // Writable field masks
  localparam logic [31:0] VIC_SOFT_MASK = 32'h00000006; // Bits 2 and 1
  localparam logic [31:0] VIC_BASE_MASK = 32'h0000FFFF; // Upper half reads 0
  localparam logic [31:0] VIC_PRIO0_MASK = 32'h77777770; // Source 0 has no field
  localparam logic [31:0] VIC_PRIO1_MASK = 32'h77777777;
  localparam logic [31:0] VIC_PRIO2_MASK = 32'h00777777;
  localparam logic [31:0] VIC_VCTL_MASK = 32'h00000003;
  localparam logic [31:0] VIC_EVT_FMASK = 32'h00000003;

  // Field positions
  localparam int VIC_SOFT_NRM_BIT = 1; // Programmed normal request
  localparam int VIC_SOFT_FST_BIT = 2; // Programmed fast request
  localparam int VIC_SOFT_SRC = 1; // Source slot of programmed interrupts
  localparam int VIC_PRIO_SRCS = 24; // Sources 0 to 23 index a priority slot; only sources 1 to 21 have writable fields

  // Reset values
  localparam logic [31:0] VIC_REG_RST = 32'h00000000;
  localparam logic [7:0] VIC_INSVC_RST = 8'h00;
  localparam logic [3:0] VIC_LVL_NONE = 4'h8; // No handler in service

  // Arbitration result
  typedef struct packed {
    logic valid;
    logic [4:0] src;
    logic [2:0] lvl;
  } vic_pick_s;

endpackage : vic_pkg

// >>> rtl/vic_ctrl.sv
// Vectored interrupt controller: normal and fast request paths,
// programmed interrupts, priorities, nesting and vector addresses.
// Assumes sources and register strobes are synchronous to core_clk_in.
//
// Added by the designer: the address-and-strobe port.
`timescale 1ns/1ps
module vic_ctrl
  import vic_pkg::*;
(
  input wire logic core_clk_in, // 25 MHz core clock
  input wire logic reset_in, // Async, active high
  input wire logic [31:0] src_in, // Peripheral request levels
  input wire logic [31:0] reg_addr_in, // Register byte address
  input wire logic [31:0] reg_wdata_in, // Write data
  input wire logic reg_wr_in, // Write strobe
  input wire logic reg_rd_in, // Read strobe
  output logic [31:0] reg_rdata_out, // Read data, cycle after strobe
  output logic normal_req_out, // Normal request to core
  output logic fast_req_out, // Fast request to core
  output logic ctrl_irq_out // Event interrupt
);

  // Index 0 is the normal path, index 1 the fast path
  logic [31:0] raw [2]; // Raw signal registers
  logic [31:0] en [2]; // Enable registers
  logic [31:0] sta [2]; // Status, combinational
  logic [7:0] insvc [2]; // In-service priority levels
  vic_pick_s pick [2]; // Winning source per path
  logic [1:0] req; // Request per path
  logic [1:0] take; // Vector read taken
  logic [1:0] eoi; // End of handler write
  logic [31:0] soft_cfg; // Programmed interrupt config
  logic [15:0] tbl_base; // Vector table base
  logic [31:0] prio [3]; // Priority registers
  logic [1:0] vec_en; // Vectoring enable per path
  logic [1:0] evt_sta; // Sticky events
  logic [1:0] evt_mask; // Event mask
  logic [1:0] evt_set; // Event pulses
  logic wr_hit_sta; // Event clear write

  // Priority of one source; unprioritised sources sit at level 0
  function automatic logic [2:0] prio_of(input logic [31:0] p0,
    input logic [31:0] p1, input logic [31:0] p2, input int k);
    logic [95:0] flat;
    flat = {p2, p1, p0};
    if (k >= VIC_PRIO_SRCS)
      return 3'h0;
    return flat[(k / 8) * 32 + (k % 8) * 4 +: 3];
  endfunction : prio_of

  // Index of the lowest set bit, 8 when empty
  function automatic logic [3:0] top_lvl(input logic [7:0] m);
    logic [3:0] r;
    r = VIC_LVL_NONE;
    for (int i = 7; i >= 0; i--)
    begin
      if (m[i])
        r = 4'(i);
    end
    return r;
  endfunction : top_lvl

  // Best pending source above the level now in service
  function automatic vic_pick_s arbitrate(input logic [31:0] pend,
    input logic [7:0] busy, input logic [31:0] p0,
    input logic [31:0] p1, input logic [31:0] p2);
    vic_pick_s p;
    logic [2:0] l;
    logic [3:0] top;
    p = '0;
    top = top_lvl(busy);
    for (int k = 0; k < 32; k++)
    begin
      l = prio_of(p0, p1, p2, k);
      // Strict compare keeps the lowest index on a tie
      if (pend[k] && ({1'b0, l} < top) && (!p.valid || l < p.lvl))
      begin
        p.valid = 1'b1;
        p.src = 5'(k);
        p.lvl = l;
      end
    end
    return p;
  endfunction : arbitrate

  // Handler pointer slot: four bytes per source, 32 slots
  function automatic logic [31:0] vec_word(input logic [15:0] b,
    input vic_pick_s p);
    return {9'h000, b, p.src, 2'b00};
  endfunction : vec_word

  // Status and arbitration, both paths
  always_comb
  begin
    for (int t = 0; t < 2; t++)
    begin
      // Programmed slot bypasses the enable
      sta[t] = (raw[t] & en[t]) | (raw[t] & (32'h1 << VIC_SOFT_SRC));
      // Encoder runs only with vectoring on; plain vector reads see source 0
      if (vec_en[t])
        pick[t] = arbitrate(sta[t], insvc[t], prio[0], prio[1], prio[2]);
      else
        pick[t] = '0;
      // Plain mode: any status bit, no encoding
      req[t] = vec_en[t] ? pick[t].valid : |sta[t];
    end
  end

  // Strobe decode for vector reads and end-of-handler writes
  always_comb
  begin
    take[0] = reg_rd_in && reg_addr_in == VIC_NRM_VEC && vec_en[0] && pick[0].valid;
    take[1] = reg_rd_in && reg_addr_in == VIC_FST_VEC && vec_en[1] && pick[1].valid;
    eoi[0] = reg_wr_in && reg_addr_in == VIC_NRM_EOI;
    eoi[1] = reg_wr_in && reg_addr_in == VIC_FST_EOI;
    wr_hit_sta = reg_wr_in && reg_addr_in == VIC_EVT_STA;
    // Nested take while a handler runs
    evt_set = take & {|insvc[1], |insvc[0]};
  end

  // Raw registers; slot 1 follows the programmed config
  always_ff @(posedge core_clk_in or posedge reset_in)
  begin
    if (reset_in)
    begin
      raw[0] <= VIC_REG_RST;
      raw[1] <= VIC_REG_RST;
    end
    else
    begin
      // Sources are seen if high at a single sample
      raw[0] <= {src_in[31:2], soft_cfg[VIC_SOFT_NRM_BIT], src_in[0]};
      raw[1] <= {src_in[31:2], soft_cfg[VIC_SOFT_FST_BIT], src_in[0]};
    end
  end

  // Software-written configuration
  always_ff @(posedge core_clk_in or posedge reset_in)
  begin
    if (reset_in)
    begin
      en[0] <= VIC_REG_RST;
      en[1] <= VIC_REG_RST;
      soft_cfg <= VIC_REG_RST;
      tbl_base <= VIC_REG_RST[15:0];
      prio[0] <= VIC_REG_RST;
      prio[1] <= VIC_REG_RST;
      prio[2] <= VIC_REG_RST;
      vec_en <= VIC_REG_RST[1:0];
      evt_mask <= VIC_REG_RST[1:0];
    end
    else if (reg_wr_in)
    begin
      case (reg_addr_in)
        VIC_NRM_EN: en[0] <= reg_wdata_in;
        VIC_FST_EN: en[1] <= reg_wdata_in;
        VIC_SOFT_CFG: soft_cfg <= reg_wdata_in & VIC_SOFT_MASK;
        VIC_TBL_BASE: tbl_base <= reg_wdata_in[15:0];
        // Reserved field bits stay zero
        VIC_PRIO0: prio[0] <= reg_wdata_in & VIC_PRIO0_MASK;
        VIC_PRIO1: prio[1] <= reg_wdata_in & VIC_PRIO1_MASK;
        VIC_PRIO2: prio[2] <= reg_wdata_in & VIC_PRIO2_MASK;
        VIC_VEC_CTRL: vec_en <= reg_wdata_in[1:0];
        VIC_EVT_MASK: evt_mask <= reg_wdata_in[1:0];
        default: ; // Read-only or unmapped
      endcase
    end
  end

  // Nesting: a vector read that takes a winner with vectoring on pushes, an end write pops the top level
  always_ff @(posedge core_clk_in or posedge reset_in)
  begin
    if (reset_in)
    begin
      insvc[0] <= VIC_INSVC_RST;
      insvc[1] <= VIC_INSVC_RST;
    end
    else
    begin
      for (int t = 0; t < 2; t++)
      begin
        // Pop first so a same-cycle take is kept
        insvc[t] <= (eoi[t] ? (insvc[t] & (insvc[t] - 8'h01)) : insvc[t])
          | (take[t] ? (8'h01 << pick[t].lvl) : 8'h00);
      end
    end
  end

  // Sticky events, write one to clear; a new event wins
  always_ff @(posedge core_clk_in or posedge reset_in)
  begin
    if (reset_in)
      evt_sta <= VIC_REG_RST[1:0];
    else
      evt_sta <= (evt_sta & ~(wr_hit_sta ? reg_wdata_in[1:0] : 2'b00)) | evt_set;
  end

  // Requests to the core; fast masks normal
  always_ff @(posedge core_clk_in or posedge reset_in)
  begin
    if (reset_in)
    begin
      normal_req_out <= 1'b0;
      fast_req_out <= 1'b0;
      ctrl_irq_out <= 1'b0;
    end
    else
    begin
      fast_req_out <= req[1];
      normal_req_out <= req[0] && !req[1];
      // Event interrupt reflects next status so set and output align
      ctrl_irq_out <= |(((evt_sta & ~(wr_hit_sta ? reg_wdata_in[1:0] : 2'b00))
        | evt_set) & evt_mask);
    end
  end

  // Read data, one cycle after the strobe
  always_ff @(posedge core_clk_in or posedge reset_in)
  begin
    if (reset_in)
      reg_rdata_out <= VIC_REG_RST;
    else if (reg_rd_in)
    begin
      case (reg_addr_in)
        VIC_NRM_STA: reg_rdata_out <= sta[0];
        VIC_NRM_RAW: reg_rdata_out <= raw[0];
        VIC_NRM_EN: reg_rdata_out <= en[0];
        VIC_FST_STA: reg_rdata_out <= sta[1];
        VIC_FST_RAW: reg_rdata_out <= raw[1];
        VIC_FST_EN: reg_rdata_out <= en[1];
        VIC_SOFT_CFG: reg_rdata_out <= soft_cfg;
        VIC_TBL_BASE: reg_rdata_out <= {16'h0000, tbl_base};
        VIC_NRM_VEC: reg_rdata_out <= vec_word(tbl_base, pick[0]);
        VIC_FST_VEC: reg_rdata_out <= vec_word(tbl_base, pick[1]);
        VIC_PRIO0: reg_rdata_out <= prio[0];
        VIC_PRIO1: reg_rdata_out <= prio[1];
        VIC_PRIO2: reg_rdata_out <= prio[2];
        VIC_VEC_CTRL: reg_rdata_out <= {30'h00000000, vec_en};
        VIC_EVT_STA: reg_rdata_out <= {30'h00000000, evt_sta};
        VIC_EVT_MASK: reg_rdata_out <= {30'h00000000, evt_mask};
        default: reg_rdata_out <= VIC_REG_RST; // Unmapped reads zero
      endcase
    end
  end

  // Checks
  sequence s_soft_wr;
    reg_wr_in && reg_addr_in == VIC_SOFT_CFG;
  endsequence

  sequence s_fast_take;
    take[1] ##1 1'b1;
  endsequence

  a_fast_req_plain: assert property (@(posedge core_clk_in) disable iff (reset_in)
    !vec_en[1] |=> fast_req_out == $past(|(raw[1] & en[1]) || raw[1][1]))
    else $error("fast request does not follow fast status");

  a_soft_fast_bit: assert property (@(posedge core_clk_in) disable iff (reset_in)
    s_soft_wr ##2 1'b1 |-> raw[1][1] == $past(reg_wdata_in[2], 2) && sta[1][1] == raw[1][1])
    else $error("programmed fast bit not applied");

  a_soft_norm_bit: assert property (@(posedge core_clk_in) disable iff (reset_in)
    s_soft_wr ##2 1'b1 |-> raw[0][1] == $past(reg_wdata_in[1], 2) && sta[0][1] == raw[0][1])
    else $error("programmed normal bit not applied");

  a_fast_over_norm: assert property (@(posedge core_clk_in) disable iff (reset_in)
    fast_req_out |-> !normal_req_out)
    else $error("normal request raised beside fast request");

  a_plain_no_nest: assert property (@(posedge core_clk_in) disable iff (reset_in)
    reg_rd_in && reg_addr_in == VIC_FST_VEC && !vec_en[1] && !eoi[1] |=> $stable(insvc[1]))
    else $error("non-vectored read changed nesting");

  a_nest_push: assert property (@(posedge core_clk_in) disable iff (reset_in)
    s_fast_take |-> insvc[1][$past(pick[1].lvl)] && fast_req_out == $past(req[1]))
    else $error("taken level not marked in service");

  a_preempt_only: assert property (@(posedge core_clk_in) disable iff (reset_in)
    vec_en[1] && pick[1].valid |-> {1'b0, pick[1].lvl} < top_lvl(insvc[1]))
    else $error("winner does not preempt current level");

  a_vec_addr: assert property (@(posedge core_clk_in) disable iff (reset_in)
    take[0] |=> reg_rdata_out == {9'h000, $past(tbl_base), $past(pick[0].src), 2'b00})
    else $error("vector address wrong");

  a_prio_reserved: assert property (@(posedge core_clk_in) disable iff (reset_in)
    reg_rd_in && reg_addr_in == VIC_PRIO0 |=> reg_rdata_out[3:0] == 4'h0 && !reg_rdata_out[31])
    else $error("reserved priority bits not zero");

  a_base_upper: assert property (@(posedge core_clk_in) disable iff (reset_in)
    reg_rd_in && reg_addr_in == VIC_TBL_BASE |=> reg_rdata_out[31:16] == 16'h0000)
    else $error("table base upper half not zero");

  // Plain fast vector reads carry no encoded source
  a_plain_vec_zero: assert property (@(posedge core_clk_in) disable iff (reset_in)
    reg_rd_in && reg_addr_in == VIC_FST_VEC && !vec_en[1] |=> reg_rdata_out[6:2] == 5'h00)
    else $error("plain fast vector read returned an encoded source");

  // Fast vector word holds table base and winning source
  a_fast_vec_addr: assert property (@(posedge core_clk_in) disable iff (reset_in)
    take[1] |=> reg_rdata_out == {9'h000, $past(tbl_base), $past(pick[1].src), 2'b00})
    else $error("fast vector address wrong");

  // Fast status read back is raw under enable, programmed slot always passes
  a_fast_sta_read: assert property (@(posedge core_clk_in) disable iff (reset_in)
    reg_rd_in && reg_addr_in == VIC_FST_STA
    |=> reg_rdata_out == $past((raw[1] & en[1]) | (raw[1] & 32'h00000002)))
    else $error("fast status read is not raw AND enable");

  // Programmed normal bit reaches status with its enable clear
  a_soft_unmasked: assert property (@(posedge core_clk_in) disable iff (reset_in)
    raw[0][1] && !en[0][1] |-> sta[0][1])
    else $error("programmed interrupt was masked");

  // Plain normal request follows status unless fast is raised
  a_norm_req_plain: assert property (@(posedge core_clk_in) disable iff (reset_in)
    !vec_en[0] |=> normal_req_out == $past(|sta[0] && !req[1]))
    else $error("normal request does not follow normal status");

  // End write while a fast handler runs, with no take beside it
  sequence s_fast_eoi;
    eoi[1] && !take[1] && insvc[1] != 8'h00;
  endsequence

  // A pop clears exactly one level, the innermost, and sets none
  a_nest_pop: assert property (@(posedge core_clk_in) disable iff (reset_in)
    s_fast_eoi |=> $countones(insvc[1]) + 1 == $countones($past(insvc[1]))
      && (insvc[1] & ~$past(insvc[1])) == 8'h00
      && top_lvl(insvc[1]) > top_lvl($past(insvc[1])))
    else $error("end write did not drop the innermost level");

  // Priority register 1 fields never hold their top bit
  a_prio1_reserved: assert property (@(posedge core_clk_in) disable iff (reset_in)
    reg_rd_in && reg_addr_in == VIC_PRIO1 |=> (reg_rdata_out & 32'h88888888) == 32'h00000000)
    else $error("priority register 1 reserved bits not zero");

  // Pending lower-numbered source at the winner's level or better
  function automatic logic lower_rival(input logic [31:0] pend, input vic_pick_s p,
    input logic [31:0] p0, input logic [31:0] p1, input logic [31:0] p2);
    logic r;
    r = 1'b0;
    for (int k = 0; k < 32; k++)
    begin
      // Such a rival should have won, so any hit is an arbitration fault
      if (pend[k] && k < int'(p.src) && prio_of(p0, p1, p2, k) <= p.lvl)
        r = 1'b1;
    end
    return r;
  endfunction : lower_rival

  a_tie_lowest: assert property (@(posedge core_clk_in) disable iff (reset_in)
    vec_en[1] && pick[1].valid |-> !lower_rival(sta[1], pick[1], prio[0], prio[1], prio[2]))
    else $error("winner is not the lowest source at its level");

  // Event output is the sticky status under last cycle's mask
  a_irq_level: assert property (@(posedge core_clk_in) disable iff (reset_in)
    1'b1 |=> ctrl_irq_out == (|(evt_sta & $past(evt_mask))))
    else $error("event interrupt does not follow masked status");

  // A nested take sets its event even beside a clear
  a_evt_set_wins: assert property (@(posedge core_clk_in) disable iff (reset_in)
    evt_set[1] |=> evt_sta[1])
    else $error("nesting event lost");

  // Vectored fast request follows the arbiter
  a_fast_req_vec: assert property (@(posedge core_clk_in) disable iff (reset_in)
    vec_en[1] |=> fast_req_out == $past(pick[1].valid))
    else $error("vectored fast request does not follow arbiter");

endmodule : vic_ctrl

// >>> dv/vic_core_model.sv
// Behavioural model of the processor core that receives both request lines.
// Assumes the requests are levels synchronous to the core clock.
`timescale 1ns/1ps
module vic_core_model
(
  input wire logic core_clk_in, // Core clock
  input wire logic reset_in, // Async, active high
  input wire logic normal_req_in, // Normal request level
  input wire logic fast_req_in, // Fast request level
  output logic normal_entry_out, // Core inside a normal handler
  output logic fast_entry_out // Core inside a fast handler
);
  // Core samples the request levels once per edge, as a real core would
  always_ff @(posedge core_clk_in or posedge reset_in)
  begin
    if (reset_in)
    begin
      normal_entry_out <= 1'b0;
      fast_entry_out <= 1'b0;
    end
    else
    begin
      // Fast entry masks normal entry inside the core as well
      fast_entry_out <= fast_req_in;
      normal_entry_out <= normal_req_in & ~fast_req_in;
    end
  end
endmodule : vic_core_model

// >>> dv/vic_ctrl_bench.sv
// Self-checking bench for the vectored interrupt controller.
// Assumes the register map and field masks of vic_pkg.
`timescale 1ns/1ps
module vic_ctrl_bench;
  import vic_pkg::*;
  logic clk, rst, wr, rd, nreq, freq, irq, core_n, core_f; // Bench nets
  logic [31:0] src, addr, wdata, rdata; // Bus and sources
  int n_mismatch, n_compared, cyc; // Counters
  vic_ctrl dut (.core_clk_in(clk), .reset_in(rst), .src_in(src), .reg_addr_in(addr),
    .reg_wdata_in(wdata), .reg_wr_in(wr), .reg_rd_in(rd), .reg_rdata_out(rdata),
    .normal_req_out(nreq), .fast_req_out(freq), .ctrl_irq_out(irq));
  vic_core_model core (.core_clk_in(clk), .reset_in(rst), .normal_req_in(nreq),
    .fast_req_in(freq), .normal_entry_out(core_n), .fast_entry_out(core_f));
  // 25 MHz clock
  initial
  begin
    clk = 1'b0;
    forever #20 clk = ~clk;
  end
  // Comparison with case equality so unknowns never match
  task automatic check(input logic [31:0] seen, input logic [31:0] exp);
    n_compared++;
    if (seen !== exp)
    begin
      n_mismatch++;
      $display("[FAIL] t=%0t seen=%h expected=%h", $time, seen, exp);
    end
  endtask : check
  // One-cycle write strobe
  task automatic wr_reg(input logic [31:0] a, input logic [31:0] v);
    @(posedge clk);
    wr <= 1'b1;
    addr <= a;
    wdata <= v;
    @(posedge clk);
    wr <= 1'b0;
  endtask : wr_reg
  // Read data are taken the cycle after the strobe, once settled
  task automatic rd_chk(input logic [31:0] a, input logic [31:0] exp);
    @(posedge clk);
    rd <= 1'b1;
    addr <= a;
    @(posedge clk);
    rd <= 1'b0;
    #1;
    check(rdata, exp);
  endtask : rd_chk
  // Vector word for the table base used below
  function automatic logic [31:0] vec(input logic [4:0] s);
    vec = {9'h000, 16'h1234, s, 2'h0};
  endfunction : vec
  // Single exit point
  task automatic give_verdict();
    $display("compared=%0d mismatches=%0d", n_compared, n_mismatch);
    if (n_mismatch == 0 && n_compared > 0)
      $display("Test passed");
    else
      $display("Test failed");
    $finish;
  endtask : give_verdict
  // Hang guard: the sequence needs under two hundred cycles
  always @(posedge clk)
  begin
    cyc++;
    if (cyc == 3000)
    begin
      n_mismatch++;
      give_verdict();
    end
  end
  // Main sequence
  initial
  begin
    rst = 1'b1;
    wr = 1'b0;
    rd = 1'b0;
    addr = 32'h00000000;
    wdata = 32'h00000000;
    src = 32'h00000000;
    repeat (20) @(posedge clk);
    rst <= 1'b0;
    // Reset values and access kinds
    rd_chk(VIC_TBL_BASE, 32'h00000000);
    rd_chk(VIC_PRIO0, 32'h00000000);
    rd_chk(VIC_FST_STA, 32'h00000000);
    wr_reg(VIC_TBL_BASE, 32'hFFFFFFFF);
    rd_chk(VIC_TBL_BASE, 32'h0000FFFF);
    wr_reg(VIC_PRIO0, 32'hFFFFFFFF);
    rd_chk(VIC_PRIO0, 32'h77777770);
    wr_reg(VIC_PRIO1, 32'hFFFFFFFF);
    rd_chk(VIC_PRIO1, 32'h77777777);
    wr_reg(VIC_FST_STA, 32'hFFFFFFFF);
    rd_chk(VIC_FST_STA, 32'h00000000);
    rd_chk(32'hFFFF0FF0, 32'h00000000);
    // Fast status is raw masked by enable; sources held several cycles
    wr_reg(VIC_FST_EN, 32'h00000010);
    wr_reg(VIC_NRM_EN, 32'h00000040);
    src <= 32'h00000070;
    repeat (3) @(posedge clk);
    rd_chk(VIC_FST_STA, 32'h00000010);
    check({31'h0, freq}, 32'h1);
    check({31'h0, nreq}, 32'h0);
    check({30'h0, core_n, core_f}, 32'h1);
    // Plain mode vector read: no encoding, word of source 0
    rd_chk(VIC_FST_VEC, 32'h007FFF80);
    check({31'h0, freq}, 32'h1);
    // Programmed requests ignore the enables
    wr_reg(VIC_SOFT_CFG, 32'h00000004);
    repeat (2) @(posedge clk);
    rd_chk(VIC_FST_STA, 32'h00000012);
    rd_chk(VIC_FST_RAW, 32'h00000072);
    wr_reg(VIC_SOFT_CFG, 32'h00000002);
    repeat (2) @(posedge clk);
    rd_chk(VIC_FST_STA, 32'h00000010);
    rd_chk(VIC_NRM_STA, 32'h00000042);
    rd_chk(VIC_NRM_RAW, 32'h00000072);
    wr_reg(VIC_SOFT_CFG, 32'h00000000);
    // Normal request shows once fast is gone
    wr_reg(VIC_FST_EN, 32'h00000000);
    repeat (3) @(posedge clk);
    check({30'h0, freq, nreq}, 32'h1);
    // Vectored fast path, two sources at equal level
    wr_reg(VIC_NRM_EN, 32'h00000000);
    wr_reg(VIC_FST_EN, 32'h00000030);
    wr_reg(VIC_TBL_BASE, 32'h00001234);
    wr_reg(VIC_PRIO0, 32'h00330000);
    wr_reg(VIC_VEC_CTRL, 32'h00000002);
    repeat (3) @(posedge clk);
    rd_chk(VIC_NRM_VEC, vec(5'h00));
    rd_chk(VIC_FST_VEC, vec(5'h04));
    repeat (3) @(posedge clk);
    check({31'h0, freq}, 32'h0);
    rd_chk(VIC_EVT_STA, 32'h00000000);
    // Raise source 5 above the handler in service
    wr_reg(VIC_PRIO0, 32'h00130000);
    repeat (3) @(posedge clk);
    check({31'h0, freq}, 32'h1);
    rd_chk(VIC_FST_VEC, vec(5'h05));
    rd_chk(VIC_EVT_STA, 32'h00000002);
    check({31'h0, irq}, 32'h0);
    // Nesting event: unmask, then clear by writing one
    wr_reg(VIC_EVT_MASK, 32'h00000002);
    repeat (2) @(posedge clk);
    check({31'h0, irq}, 32'h1);
    wr_reg(VIC_EVT_STA, 32'h00000002);
    repeat (2) @(posedge clk);
    check({31'h0, irq}, 32'h0);
    rd_chk(VIC_EVT_STA, 32'h00000000);
    // Both handlers finished, request returns
    wr_reg(VIC_FST_EOI, 32'h00000000);
    wr_reg(VIC_FST_EOI, 32'h00000000);
    repeat (3) @(posedge clk);
    check({31'h0, freq}, 32'h1);
    // Vectored normal path: fast off, source 6 at level 0
    wr_reg(VIC_FST_EN, 32'h00000000);
    wr_reg(VIC_NRM_EN, 32'h00000040);
    wr_reg(VIC_VEC_CTRL, 32'h00000003);
    repeat (3) @(posedge clk);
    check({30'h0, freq, nreq}, 32'h1);
    rd_chk(VIC_NRM_VEC, vec(5'h06));
    repeat (3) @(posedge clk);
    check({31'h0, nreq}, 32'h0);
    wr_reg(VIC_NRM_EOI, 32'h00000000);
    repeat (3) @(posedge clk);
    check({31'h0, nreq}, 32'h1);
    give_verdict();
  end
endmodule : vic_ctrl_bench
